// ==== rtl/rml_top.sv ====
// Reference window monitors, lock detectors and tuning word history.
// How it works
// - Pulse inside late window clears missing flag.
// - No pulse by late limit sets flag.
// - Late monitor only for 2 kHz to fvco/12.
// - Late and early flags ORed per reference.
// - Pulse after early limit clears early flag.
// - Pulse before early limit sets flag at once.
// - Early monitor only for 2 kHz to fvco/12.
// - Early detection needs late detection enabled.
// - PPS pulse inside jitter window clears flag.
// - PPS pulse missing at window end sets flag.
// - Three analog, three digital loops report lock loss.
// - Resonator check makes loop three phase-only.
// - Digital frequency lock uses lock/unlock hysteresis.
// - Resonator VCO checked against XO with hysteresis.
// - Accuracy and averaging lengthen delay; averaging caps threshold.
// - Phase lock uses lock/unlock hysteresis.
// - Tuning word source follows loop mode.
// - Average loop filter while locked, keep for holdover.
// - On failure drop running and latest average.
// - Resets clear history; first period waits.
// - History survives switchover; enable toggle clears.
// - Without history holdover uses free-run word.
`default_nettype none
module rml_top #(
  parameter int NREF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NREF-1:0] ref_in,
  input wire logic [5:0][rml_pkg::EW-1:0] freq_err,
  input wire logic [2:0][rml_pkg::EW-1:0] phase_err,
  input wire logic ref_valid,
  input wire logic pll_locked,
  input wire logic [rml_pkg::TW-1:0] lf_word,
  output logic [NREF-1:0] ref_window_flag,
  output logic [5:0] freq_lock_loss,
  output logic [2:0] phase_lock_loss,
  output logic [rml_pkg::TW-1:0] tuning_word
);
  if (NREF < 1 || NREF > 4) begin : g_chk
    $error("NREF must lie between 1 and 4");
  end
  logic [6:0] ctrl_q;
  logic [11:0] win_q;
  logic [rml_pkg::CW-1:0] nom_q, late_q, early_q, jit_q;
  logic [31:0] flock_q, plock_q, free_q, prdata_q, rdata, tune_q;
  logic [31:0] htim_q, hlast_q, hprev_q;
  logic [7:0] fmeas_q;
  logic [4:0] hlog_q;
  logic srst_q, pready_q, pslverr_q, hit, wr, apll3, hist_en;
  logic [NREF-1:0] s1_q, s2_q, s3_q, win_flag, win_flag_q;
  logic [2:0] den;
  logic [5:0] f_act;
  rml_pkg::rml_mode_e mode_q;
  logic [63:0] hsum_q;
  logic [1:0] hcnt_q;
  assign den = ctrl_q[rml_pkg::C_DEN +: 3];
  assign apll3 = ctrl_q[rml_pkg::C_APLL3];
  assign hist_en = ctrl_q[rml_pkg::C_HIST];
  // ==========================================================
  // APB slave
  // One wait state: data and error are registered in the first
  // access cycle and pready rises in the second.
  assign wr = psel && penable && pready_q && pwrite;
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      rml_pkg::A_CTRL: rdata = {25'h0, ctrl_q};
      rml_pkg::A_WIN_EN: rdata = {20'h0, win_q};
      rml_pkg::A_NOMINAL: rdata = {4'h0, nom_q};
      rml_pkg::A_LATE: rdata = {4'h0, late_q};
      rml_pkg::A_EARLY: rdata = {4'h0, early_q};
      rml_pkg::A_JITTER: rdata = {4'h0, jit_q};
      rml_pkg::A_FLOCK: rdata = flock_q;
      rml_pkg::A_PLOCK: rdata = plock_q;
      rml_pkg::A_FMEAS: rdata = {24'h0, fmeas_q};
      rml_pkg::A_HIST_T: rdata = {27'h0, hlog_q};
      rml_pkg::A_FREE: rdata = free_q;
      rml_pkg::A_STATUS: begin
        rdata[rml_pkg::S_WIN +: 4] = 4'(win_flag_q);
        rdata[rml_pkg::S_FLL +: 6] = freq_lock_loss;
        rdata[rml_pkg::S_PLL +: 3] = phase_lock_loss;
        rdata[rml_pkg::S_HV] = hcnt_q != 2'h0;
        rdata[rml_pkg::S_MODE +: 2] = 2'(mode_q);
      end
      rml_pkg::A_TUNE: rdata = tune_q;
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (pclk_en) begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= hit ? rdata : 32'h0000_0000;
      end
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rml_pkg::CTRL_RST;
      win_q <= 12'h000;
      nom_q <= '0;
      late_q <= '0;
      early_q <= '0;
      jit_q <= '0;
      flock_q <= rml_pkg::FLOCK_RST;
      plock_q <= rml_pkg::PLOCK_RST;
      fmeas_q <= rml_pkg::FMEAS_RST;
      hlog_q <= rml_pkg::HIST_RST;
      free_q <= rml_pkg::FREE_RST;
    end else if (pclk_en && wr) begin
      case (paddr)
        rml_pkg::A_CTRL: ctrl_q <= {pwdata[6:1], 1'b0};
        rml_pkg::A_WIN_EN: win_q <= pwdata[11:0];
        rml_pkg::A_NOMINAL: nom_q <= pwdata[27:0];
        rml_pkg::A_LATE: late_q <= pwdata[27:0];
        rml_pkg::A_EARLY: early_q <= pwdata[27:0];
        rml_pkg::A_JITTER: jit_q <= pwdata[27:0];
        rml_pkg::A_FLOCK: flock_q <= pwdata;
        rml_pkg::A_PLOCK: plock_q <= pwdata;
        rml_pkg::A_FMEAS: fmeas_q <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        rml_pkg::A_HIST_T: begin
          hlog_q <= (pwdata[4:0] > 5'(rml_pkg::HLOG_MAX)) ?
                    5'(rml_pkg::HLOG_MAX) : pwdata[4:0];
        end
        rml_pkg::A_FREE: free_q <= pwdata;
        default: ;
      endcase
    end
  end
  // Soft reset is a one-cycle pulse that clears detectors and history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_q <= 1'b0;
    end else if (pclk_en) begin
      srst_q <= wr && paddr == rml_pkg::A_CTRL && pwdata[rml_pkg::C_SRST];
    end
  end
  // ==========================================================
  // Reference inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      win_flag_q <= '0;
    end else if (pclk_en) begin
      s1_q <= ref_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      win_flag_q <= win_flag;
    end
  end
  assign ref_window_flag = win_flag_q;
  for (genvar r = 0; r < NREF; r++) begin : g_ref
    rml_win_if w ();
    assign w.pulse = s2_q[r] & ~s3_q[r];
    assign w.late_en = win_q[rml_pkg::W_LATE + r];
    assign w.early_en = win_q[rml_pkg::W_EARLY + r];
    assign w.pps_en = win_q[rml_pkg::W_PPS + r];
    assign w.late_lim = nom_q + late_q;
    assign w.early_lim = (early_q > nom_q) ? '0 : nom_q - early_q;
    assign w.pps_lim = nom_q + jit_q;
    assign win_flag[r] = w.flag;
    rml_window_det u_det (
      .pclk(pclk),
      .presetn(presetn),
      .ce(pclk_en),
      .srst(srst_q),
      .w(w)
    );
  end
  // ==========================================================
  // Frequency lock detectors: 0-2 digital loops, 3-5 analog loops
  // six frequency detectors
  assign f_act = {apll3 & den[2], 2'b11, den & {~apll3, 2'b11}};
  logic [3:0] f_log;
  logic [14:0] f_last;
  logic [15:0] f_cap, f_unl;
  assign f_log = {1'b0, fmeas_q[rml_pkg::F_ACC +: 3]} +
                 {1'b0, fmeas_q[rml_pkg::F_AVG +: 3]};
  assign f_last = (15'h1 << f_log) - 15'h1;
  assign f_cap = 16'hffff >> fmeas_q[rml_pkg::F_AVG +: 3];
  assign f_unl = (flock_q[31:16] > f_cap) ? f_cap : flock_q[31:16];
  for (genvar i = 0; i < 6; i++) begin : g_fl
    logic [31:0] sum_q, nsum;
    logic [14:0] cnt_q;
    logic flag_q;
    logic [15:0] avg;
    assign nsum = sum_q + {16'h0, freq_err[i]};
    assign avg = 16'(nsum >> f_log);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sum_q <= 32'h0000_0000;
        cnt_q <= 15'h0000;
        flag_q <= 1'b0;
      end else if (pclk_en) begin
        if (srst_q || !f_act[i]) begin
          sum_q <= 32'h0000_0000;
          cnt_q <= 15'h0000;
          flag_q <= 1'b0;
        end else if (cnt_q == f_last) begin
          sum_q <= 32'h0000_0000;
          cnt_q <= 15'h0000;
          if (avg < flock_q[15:0]) begin
            flag_q <= 1'b0;
          end else if (avg > f_unl) begin
            flag_q <= 1'b1;
          end
        end else begin
          sum_q <= nsum;
          cnt_q <= cnt_q + 15'h1;
        end
      end
    end
    assign freq_lock_loss[i] = flag_q;
  end
  // ==========================================================
  // Phase lock detectors for the digital loops
  for (genvar i = 0; i < 3; i++) begin : g_pl
    logic flag_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_q <= 1'b0;
      end else if (pclk_en) begin
        if (srst_q || !den[i] || phase_err[i] < plock_q[15:0]) begin
          flag_q <= 1'b0;
        end else if (phase_err[i] > plock_q[31:16]) begin
          flag_q <= 1'b1;
        end
      end
    end
    assign phase_lock_loss[i] = flag_q;
  end
  // ==========================================================
  // Loop mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= rml_pkg::RML_FREE;
    end else if (pclk_en) begin
      if (srst_q) begin
        mode_q <= rml_pkg::RML_FREE;
      end else begin
        case (mode_q)
          rml_pkg::RML_FREE, rml_pkg::RML_HOLD: begin
            if (ref_valid && pll_locked) begin
              mode_q <= rml_pkg::RML_LOCKED;
            end
          end
          rml_pkg::RML_LOCKED: begin
            if (!ref_valid) begin
              mode_q <= rml_pkg::RML_HOLD;
            end
          end
          default: mode_q <= rml_pkg::RML_FREE;
        endcase
      end
    end
  end
  // ==========================================================
  // Tuning word history
  // The averaging time is a power of two so the mean is a shift,
  // which trades timer resolution for a divider-free datapath.
  logic h_end, h_fail;
  logic [63:0] hsum_n;
  assign h_end = htim_q == ((32'h1 << hlog_q) - 32'h1);
  assign h_fail = mode_q == rml_pkg::RML_LOCKED && !ref_valid;
  assign hsum_n = hsum_q + {32'h0, lf_word};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsum_q <= 64'h0;
      htim_q <= 32'h0;
      hlast_q <= 32'h0;
      hprev_q <= 32'h0;
      hcnt_q <= 2'h0;
    end else if (pclk_en) begin
      if (srst_q || !hist_en) begin
        hsum_q <= 64'h0;
        htim_q <= 32'h0;
        hlast_q <= 32'h0;
        hprev_q <= 32'h0;
        hcnt_q <= 2'h0;
      end else if (h_fail) begin
        hsum_q <= 64'h0;
        htim_q <= 32'h0;
        hlast_q <= hprev_q;
        hcnt_q <= (hcnt_q == 2'h2) ? 2'h1 : 2'h0;
      end else if (mode_q == rml_pkg::RML_LOCKED) begin
        if (h_end) begin
          hprev_q <= hlast_q;
          hlast_q <= 32'(hsum_n >> hlog_q);
          hcnt_q <= (hcnt_q == 2'h2) ? 2'h2 : hcnt_q + 2'h1;
          hsum_q <= 64'h0;
          htim_q <= 32'h0;
        end else begin
          hsum_q <= hsum_n;
          htim_q <= htim_q + 32'h1;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_q <= rml_pkg::FREE_RST;
    end else if (pclk_en) begin
      case (mode_q)
        rml_pkg::RML_LOCKED: tune_q <= lf_word;
        rml_pkg::RML_HOLD: tune_q <= (hcnt_q != 2'h0) ? hlast_q : free_q;
        default: tune_q <= free_q;
      endcase
    end
  end
  assign tuning_word = tune_q;
  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fail_one;
    pclk_en && !srst_q && hist_en && h_fail && hcnt_q == 2'h1;
  endsequence
  a_loop3_phase: assert property (pclk_en && apll3 &&
      !srst_q |=> !freq_lock_loss[2])
    else $error("loop three reports frequency loss");
  a_phase_unl: assert property (pclk_en && den[0] && !srst_q &&
      phase_err[0] > plock_q[31:16] |=> phase_lock_loss[0])
    else $error("phase lock loss not set");
  a_tune_lock: assert property (pclk_en &&
      mode_q == rml_pkg::RML_LOCKED |=> tuning_word == $past(lf_word))
    else $error("locked tuning word not from loop filter");
  a_hold_free: assert property (pclk_en && mode_q == rml_pkg::RML_HOLD
      && hcnt_q == 2'h0 |=> tuning_word == $past(free_q))
    else $error("holdover without history not free-run");
  a_fail_drop: assert property (s_fail_one |=> hcnt_q == 2'h0 &&
      mode_q == rml_pkg::RML_HOLD)
    else $error("single average kept after failure");
  a_hist_clear: assert property (pclk_en && !hist_en |=>
      hcnt_q == 2'h0 && hsum_q == 64'h0)
    else $error("history not cleared by enable low");
  a_srst_clear: assert property (pclk_en && srst_q |=>
      mode_q == rml_pkg::RML_FREE && hcnt_q == 2'h0)
    else $error("soft reset left history");
  a_apb_wait: assert property (pclk_en && psel && penable && !pready_q
      |=> pready)
    else $error("access not answered");
endmodule
`default_nettype wire

// ==== rtl/rml_pkg.sv ====
// Shared constants and types for the reference monitor and lock history.
`default_nettype none
package rml_pkg;
  // ==========================================================
  // Widths
  localparam int CW = 28;
  localparam int EW = 16;
  localparam int TW = 32;
  localparam int HLOG_MAX = 24;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WIN_EN = 8'h04;
  localparam logic [7:0] A_NOMINAL = 8'h08;
  localparam logic [7:0] A_LATE = 8'h0c;
  localparam logic [7:0] A_EARLY = 8'h10;
  localparam logic [7:0] A_JITTER = 8'h14;
  localparam logic [7:0] A_FLOCK = 8'h18;
  localparam logic [7:0] A_PLOCK = 8'h1c;
  localparam logic [7:0] A_FMEAS = 8'h20;
  localparam logic [7:0] A_HIST_T = 8'h24;
  localparam logic [7:0] A_FREE = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h2c;
  localparam logic [7:0] A_TUNE = 8'h30;
  // ==========================================================
  // Field positions
  localparam int C_SRST = 0;
  localparam int C_APLL3 = 1;
  localparam int C_HIST = 2;
  localparam int C_DEN = 4;
  localparam int W_LATE = 0;
  localparam int W_EARLY = 4;
  localparam int W_PPS = 8;
  localparam int F_ACC = 0;
  localparam int F_AVG = 4;
  localparam int S_WIN = 0;
  localparam int S_FLL = 4;
  localparam int S_PLL = 10;
  localparam int S_HV = 13;
  localparam int S_MODE = 14;
  // ==========================================================
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [31:0] FLOCK_RST = 32'h0100_0040;
  localparam logic [31:0] PLOCK_RST = 32'h0100_0040;
  localparam logic [7:0] FMEAS_RST = 8'h00;
  localparam logic [4:0] HIST_RST = 5'h14;
  localparam logic [31:0] FREE_RST = 32'h0000_0000;
  typedef enum logic [1:0] {RML_FREE, RML_LOCKED, RML_HOLD} rml_mode_e;
endpackage
`default_nettype wire

// ==== rtl/rml_win_if.sv ====
// Configuration and flag bundle between the top and one window detector.
`default_nettype none
interface rml_win_if;
  logic pulse;
  logic late_en;
  logic early_en;
  logic pps_en;
  logic [rml_pkg::CW-1:0] late_lim;
  logic [rml_pkg::CW-1:0] early_lim;
  logic [rml_pkg::CW-1:0] pps_lim;
  logic flag;
  modport det(input pulse, late_en, early_en, pps_en, late_lim,
              early_lim, pps_lim, output flag);
  modport ctl(output pulse, late_en, early_en, pps_en, late_lim,
              early_lim, pps_lim, input flag);
endinterface
`default_nettype wire

// ==== rtl/rml_window_det.sv ====
// Late, early and one-pulse-per-second window detector for one reference.
`default_nettype none
module rml_window_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic srst,
  rml_win_if.det w
);
  logic [rml_pkg::CW-1:0] cnt_q;
  logic miss_q;
  logic early_q;
  logic pv_q;
  logic early_act;

  assign early_act = w.early_en & w.late_en;

  // ==========================================================
  // Timebase
  // restart on edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (srst || w.pulse) begin
        cnt_q <= '0;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Flags
  // late window clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q <= 1'b0;
    end else if (ce) begin
      if (srst || !w.late_en) begin
        miss_q <= 1'b0;
      end else if (w.pulse) begin
        if (cnt_q < w.late_lim) begin
          miss_q <= 1'b0;
        end
      end else if (cnt_q >= w.late_lim) begin
        miss_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_q <= 1'b0;
    end else if (ce) begin
      if (srst || !early_act) begin
        early_q <= 1'b0;
      end else if (w.pulse) begin
        early_q <= cnt_q < w.early_lim;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_q <= 1'b0;
    end else if (ce) begin
      if (srst || !w.pps_en) begin
        pv_q <= 1'b0;
      end else if (w.pulse) begin
        if (cnt_q < w.pps_lim) begin
          pv_q <= 1'b0;
        end
      end else if (cnt_q >= w.pps_lim) begin
        pv_q <= 1'b1;
      end
    end
  end

  assign w.flag = miss_q | early_q | pv_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_runt;
    ce && !srst && w.pulse && early_act && cnt_q < w.early_lim;
  endsequence
  sequence s_late_gap;
    ce && !srst && w.late_en && !w.pulse && cnt_q >= w.late_lim;
  endsequence
  a_late_set: assert property (s_late_gap |=> w.flag && miss_q)
    else $error("missing pulse flag not set");
  a_late_clear: assert property (ce && !srst && w.pulse &&
      cnt_q < w.late_lim |=> !miss_q)
    else $error("missing pulse flag not cleared");
  a_runt_set: assert property (s_runt |=> early_q && w.flag)
    else $error("runt flag not set at once");
  a_early_ok: assert property (ce && !srst && w.pulse &&
      cnt_q >= w.early_lim |=> !early_q)
    else $error("early flag not cleared");
  a_pps_late: assert property (ce && !srst && w.pps_en &&
      !w.pulse && cnt_q >= w.pps_lim |=> pv_q)
    else $error("phase valid flag not set");
  a_pps_ok: assert property (ce && !srst && w.pulse &&
      cnt_q < w.pps_lim |=> !pv_q)
    else $error("phase valid flag not cleared");
endmodule
`default_nettype wire

// ==== test/rml_ref_src.sv ====
// Reference clock source model for one monitored input.
`default_nettype none
module rml_ref_src (
  input wire logic pclk,
  input wire logic en,
  input wire logic [15:0] period,
  output logic ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  initial cnt_q = 16'h0000;
  initial ref_o = 1'b0;
  // ==========================================================
  // Pulse train
  // in-range rate
  // Pulses are two cycles wide so the synchroniser never misses one.
  always @(posedge pclk) begin
    if (!en) begin
      cnt_q <= 16'h0000;
      ref_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
      ref_o <= cnt_q < 16'h0002;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the reference monitor and lock history block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ref0;
  logic [2:0] ref_hi = 3'h0;
  logic src_en = 1'b0;
  logic ce = 1'b1;
  logic [15:0] per = 16'h0014;
  logic [5:0][15:0] fe = '0;
  logic [2:0][15:0] pe = '0;
  logic ref_valid = 1'b0;
  logic pll_locked = 1'b0;
  logic [31:0] lf_word = 32'h0;
  logic [3:0] flag;
  logic [5:0] fll;
  logic [2:0] pll;
  logic [31:0] tw;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int total_checks = 0;
  always #5 pclk = ~pclk;
  rml_ref_src rml_ref_src_inst (.pclk(pclk), .en(src_en), .period(per),
    .ref_o(ref0));
  rml_top #(.NREF(4)) rml_top_inst (.pclk(pclk), .presetn(presetn),
    .pclk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_in({ref_hi, ref0}), .freq_err(fe),
    .phase_err(pe), .ref_valid(ref_valid), .pll_locked(pll_locked),
    .lf_word(lf_word), .ref_window_flag(flag), .freq_lock_loss(fll),
    .phase_lock_loss(pll), .tuning_word(tw));
  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The request is held until pready is seen, then released a cycle.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      summarize();
    end
  endtask
  function automatic logic [31:0] probe(input int s);
    case (s)
      0: return {31'h0, flag[0]};
      1: return {30'h0, fll[0], pll[0]};
      2: return {30'h0, fll[5], fll[2]};
      default: return tw;
    endcase
  endfunction
  task automatic wt(input int s, input logic [31:0] e);
    int n;
    n = 0;
    while (probe(s) !== e && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(probe(s), e);
    if (n >= 300) summarize();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, rml_pkg::A_FLOCK, 32'h0);
    chk(rd, rml_pkg::FLOCK_RST);
    apb(1'b0, rml_pkg::A_PLOCK, 32'h0);
    chk(rd, rml_pkg::PLOCK_RST);
    apb(1'b0, rml_pkg::A_HIST_T, 32'h0);
    chk(rd, {27'h0, rml_pkg::HIST_RST});
    apb(1'b1, rml_pkg::A_CTRL, 32'h1);
    apb(1'b0, rml_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_win();
    apb(1'b1, rml_pkg::A_NOMINAL, 32'h14);
    apb(1'b1, rml_pkg::A_LATE, 32'h5);
    apb(1'b1, rml_pkg::A_EARLY, 32'h5);
    apb(1'b1, rml_pkg::A_JITTER, 32'h5);
    src_en <= 1'b1;
    apb(1'b1, rml_pkg::A_WIN_EN, 32'h1);
    wt(0, 32'h0);
    src_en <= 1'b0;
    wt(0, 32'h1);
    apb(1'b0, rml_pkg::A_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    src_en <= 1'b1;
    wt(0, 32'h0);
    apb(1'b1, rml_pkg::A_WIN_EN, 32'h11);
    per <= 16'h000a;
    wt(0, 32'h1);
    per <= 16'h0014;
    wt(0, 32'h0);
    apb(1'b1, rml_pkg::A_WIN_EN, 32'h10);
    per <= 16'h000a;
    repeat (60) @(posedge pclk);
    chk(probe(0), 32'h0);
    per <= 16'h0014;
    apb(1'b1, rml_pkg::A_WIN_EN, 32'h100);
    wt(0, 32'h0);
    src_en <= 1'b0;
    wt(0, 32'h1);
    apb(1'b1, rml_pkg::A_WIN_EN, 32'h0);
    $display("windows done");
  endtask
  task automatic t_lock();
    apb(1'b1, rml_pkg::A_FMEAS, 32'h0);
    apb(1'b1, rml_pkg::A_CTRL, 32'h70);
    fe[0] <= 16'h0200;
    pe[0] <= 16'h0200;
    wt(1, 32'h3);
    fe[0] <= 16'h0080;
    pe[0] <= 16'h0080;
    repeat (20) @(posedge pclk);
    chk(probe(1), 32'h3);
    fe[0] <= 16'h0010;
    pe[0] <= 16'h0010;
    wt(1, 32'h0);
    ce <= 1'b0;
    pe[0] <= 16'h0200;
    repeat (5) @(posedge pclk);
    chk({31'h0, pll[0]}, 32'h0);
    ce <= 1'b1;
    pe[0] <= 16'h0010;
    apb(1'b1, rml_pkg::A_CTRL, 32'h72);
    fe[5] <= 16'h0200;
    fe[2] <= 16'h0200;
    wt(2, 32'h2);
    fe[5] <= 16'h0010;
    wt(2, 32'h0);
    fe[2] <= 16'h0000;
    apb(1'b1, rml_pkg::A_FLOCK, 32'hffff_0040);
    apb(1'b1, rml_pkg::A_FMEAS, 32'h70);
    fe[0] <= 16'h0300;
    wt(1, 32'h2);
    $display("lock done");
  endtask
  task automatic t_hist();
    apb(1'b1, rml_pkg::A_HIST_T, 32'h2);
    apb(1'b1, rml_pkg::A_FREE, 32'h1234_5678);
    apb(1'b1, rml_pkg::A_CTRL, 32'h74);
    lf_word <= 32'h0000_0a5a;
    ref_valid <= 1'b1;
    pll_locked <= 1'b1;
    wt(3, 32'h0000_0a5a);
    repeat (40) @(posedge pclk);
    lf_word <= 32'h0000_0fff;
    repeat (2) @(posedge pclk);
    ref_valid <= 1'b0;
    wt(3, 32'h0000_0a5a);
    apb(1'b1, rml_pkg::A_CTRL, 32'h75);
    wt(3, 32'h1234_5678);
    ref_valid <= 1'b1;
    wt(3, 32'h0000_0fff);
    ref_valid <= 1'b0;
    wt(3, 32'h1234_5678);
    ref_valid <= 1'b1;
    repeat (6) @(posedge pclk);
    ref_valid <= 1'b0;
    wt(3, 32'h1234_5678);
    $display("history done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_win();
    t_lock();
    t_hist();
    summarize();
  end
endmodule
`default_nettype wire
